// File: core/hsp_pkg.sv
// Purpose: Shared constants, types and the bit-period function of the serial register port.
// Assumes: One 250 MHz clock on both ends.
// Notes: Register addresses of the device are byte-wide, six address bits.
package hsp_pkg;
	localparam int          CLK_KHZ      = 250000;
	localparam int          CLK_NS       = 4;
	localparam int          REF_KHZ      = 27120;
	localparam int          SPI_BIT_NS   = 100;
	localparam int          SPI_HALF_CYC = (SPI_BIT_NS / 2 + CLK_NS - 1) / CLK_NS;
	localparam logic [5:0]  BAUD_ADDR    = 6'h1f;
	localparam logic [5:0]  TPEN_ADDR    = 6'h33;
	localparam int          LINE_EN_BIT  = 7;
	localparam logic [7:0]  BAUD_RST     = 8'heb;
	localparam logic [7:0]  TPEN_RST     = 8'h80;
	localparam logic [11:0] APB_CTRL     = 12'h000;
	localparam logic [11:0] APB_STAT     = 12'h004;
	localparam logic [11:0] APB_BAUD     = 12'h008;

	typedef enum logic [3:0] {
		MODE_UART = 4'b0001,
		MODE_SPI  = 4'b0010,
		MODE_I2C  = 4'b0100,
		MODE_PAR  = 4'b1000
	} hsp_mode_t;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_STOP  = 4'b1000
	} hsp_rx_t;

	// Bit period in 27.12 MHz reference ticks; bits 7:5 exponent, 4:0 mantissa.
	function automatic logic [12:0] hsp_bit_ticks(input logic [7:0] s);
		if (s[7:5] == 3'h0) begin
			return {8'h00, s[4:0]} + 13'h0001;
		end
		return ({8'h00, s[4:0]} + 13'h0021) << (s[7:5] - 3'h1);
	endfunction
endpackage

// File: core/hsp_link_if.sv
// Purpose: Pins between the serial register port and its host.
// Assumes: Undriven shared lines idle high as with a pull-up.
// Notes: Wire levels are resolved here from the output enables.
`timescale 1ns/1ps
interface hsp_link_if;
	logic nss;
	logic sck;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	logic miso;
	logic rx;
	logic tx;
	logic req_o;
	logic req_oe;
	logic req;
	logic mux_o;
	logic mux_oe;
	logic mux;

	assign miso = miso_oe ? miso_o : 1'b1;
	assign req  = req_oe ? req_o : 1'b1;
	assign mux  = mux_oe ? mux_o : 1'b1;

	modport dev  (input nss, sck, mosi, rx, output miso_o, miso_oe, tx, req_o, req_oe, mux_o,
		mux_oe);
	modport host (output nss, sck, mosi, rx, input miso, tx, req, mux);
endinterface

// File: core/hsp_device.sv
// Purpose: Device end: SPI slave and UART register access to a 64-byte register file.
// Assumes: Host pins are asynchronous and pass two flip-flops first.
// Notes: Host interface mode is taken from straps once after reset.
// Contract
// - Mode from straps after reset, held
// - SPI slave up to 10 Mbit/s
// - Host drives clock and MOSI
// - SPI bytes shift MSB first
// - Host changes MOSI on falling edges
// - MISO changes on falling clock edges
// - SPI read returns data one byte late
// - SPI write: one address, many data
// - SPI address: bit7 read, bits 6:1
// - Line enable bit gates request, mux outputs
// - UART starts at 9.6 kBd
// - Bit period from exponent and mantissa
// - Host uses documented baud settings
// - Host stays at or below 1228.8 kBd
// - UART frame: start, 8 LSB-first, stop
// - UART read returns one data byte
// - UART write stores and echoes address
// - Data byte may follow address directly
// - UART address: bit7 read, bits 5:0
`timescale 1ns/1ps
module hsp_device
	import hsp_pkg::*;
#(parameter int SYS_KHZ = CLK_KHZ)
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	hsp_link_if.dev         link,
	input  wire logic       strap_serial,
	input  wire logic       strap_i2c,
	input  wire logic       strap_ea,
	output hsp_mode_t       mode,
	output logic            reg_wr_stb,
	output logic [5:0]      reg_wr_addr,
	output logic [7:0]      reg_wr_data
);
	// ********************************************************
	// State
	// ********************************************************
	typedef struct packed {
		logic [1:0]       nss_s;
		logic [2:0]       sck_s;
		logic [1:0]       mosi_s;
		logic [2:0]       rx_s;
		logic [2:0]       st0;
		logic [2:0]       st1;
		logic [1:0]       st_age;
		hsp_mode_t        mode;
		logic [63:0][7:0] mem;
		logic [2:0]       sbit;
		logic             sfirst;
		logic             sread;
		logic [5:0]       saddr;
		logic [7:0]       srx;
		logic [7:0]       stx;
		logic             miso;
		logic [18:0]      acc;
		hsp_rx_t          rst;
		logic [12:0]      rcnt;
		logic [2:0]       rbit;
		logic [7:0]       rsh;
		logic             uhave;
		logic [7:0]       uab;
		logic             tbusy;
		logic [9:0]       tsh;
		logic [3:0]       tbit;
		logic [12:0]      tcnt;
		logic             wstb;
		logic [5:0]       waddr;
		logic [7:0]       wdata;
	} hsp_dev_t;

	hsp_dev_t r_ff;
	hsp_dev_t nxt_r;

	always_comb begin
		logic        tick;
		logic [12:0] nbit;
		logic        spi_on;
		logic        uart_on;
		logic [7:0]  b;
		logic        wr;
		logic [5:0]  wa;
		logic [7:0]  wd;
		logic        tload;
		logic [7:0]  tbyte;
		tick    = 1'b0;
		nbit    = 13'h0000;
		b       = 8'h00;
		wr      = 1'b0;
		wa      = 6'h00;
		wd      = 8'h00;
		tload   = 1'b0;
		tbyte   = 8'h00;
		nxt_r   = r_ff;
		spi_on  = (r_ff.mode == MODE_SPI);
		uart_on = (r_ff.mode == MODE_UART);

		// ********************************************************
		// Pin synchronisers and strap capture
		// ********************************************************
		nxt_r.nss_s  = {r_ff.nss_s[0], link.nss};
		nxt_r.sck_s  = {r_ff.sck_s[1:0], link.sck};
		nxt_r.mosi_s = {r_ff.mosi_s[0], link.mosi};
		nxt_r.rx_s   = {r_ff.rx_s[1:0], link.rx};
		nxt_r.st0    = {strap_serial, strap_i2c, strap_ea};
		nxt_r.st1    = r_ff.st0;
		// Straps are read once, after they have crossed both flip-flops.
		nxt_r.st_age = (r_ff.st_age == 2'h3) ? 2'h3 : r_ff.st_age + 2'h1;
		if (r_ff.st_age == 2'h2) begin
			if (!r_ff.st1[2]) begin
				nxt_r.mode = MODE_PAR;
			end else if (r_ff.st1[1]) begin
				nxt_r.mode = MODE_I2C;
			end else if (r_ff.st1[0]) begin
				nxt_r.mode = MODE_SPI;
			end else begin
				nxt_r.mode = MODE_UART;
			end
		end

		// ********************************************************
		// SPI slave
		// ********************************************************
		// Clock oversampled at 250 MHz covers 10 Mbit/s with margin.
		if (!spi_on || r_ff.nss_s[1]) begin
			nxt_r.sbit   = 3'h0;
			nxt_r.sfirst = 1'b1;
		end else if (r_ff.sck_s[1] && !r_ff.sck_s[2]) begin
			b           = {r_ff.srx[6:0], r_ff.mosi_s[1]};
			nxt_r.srx   = b;
			nxt_r.sbit  = r_ff.sbit + 3'h1;
			if (r_ff.sbit == 3'h7) begin
				nxt_r.sfirst = 1'b0;
				if (r_ff.sfirst) begin
					nxt_r.sread = b[7];
					nxt_r.saddr = b[6:1];
				end
				if (r_ff.sfirst ? b[7] : r_ff.sread) begin
					nxt_r.stx = r_ff.mem[b[6:1]];
				end else if (!r_ff.sfirst) begin
					wr = 1'b1;
					wa = r_ff.saddr;
					wd = b;
				end
			end
		end else if (!r_ff.sck_s[1] && r_ff.sck_s[2]) begin
			nxt_r.miso = r_ff.stx[7];
			nxt_r.stx  = {r_ff.stx[6:0], 1'b0};
		end

		// ********************************************************
		// UART bit timing
		// ********************************************************
		// A fractional accumulator stands in for the 27.12 MHz reference.
		nxt_r.acc = r_ff.acc + 19'(REF_KHZ);
		if (nxt_r.acc >= 19'(SYS_KHZ)) begin
			nxt_r.acc = nxt_r.acc - 19'(SYS_KHZ);
			tick      = 1'b1;
		end
		nbit = hsp_bit_ticks(r_ff.mem[BAUD_ADDR]);

		// ********************************************************
		// UART receiver and command decode
		// ********************************************************
		case (r_ff.rst)
			RX_IDLE: begin
				if (uart_on && r_ff.rx_s[2] && !r_ff.rx_s[1]) begin
					nxt_r.rst  = RX_START;
					nxt_r.rcnt = nbit >> 1;
				end
			end
			RX_START, RX_DATA, RX_STOP: begin
				if (tick) begin
					nxt_r.rcnt = r_ff.rcnt - 13'h0001;
				end
				if (tick && r_ff.rcnt == 13'h0000) begin
					nxt_r.rcnt = nbit - 13'h0001;
					if (r_ff.rst == RX_START) begin
						nxt_r.rst  = r_ff.rx_s[1] ? RX_IDLE : RX_DATA;
						nxt_r.rbit = 3'h0;
					end else if (r_ff.rst == RX_DATA) begin
						nxt_r.rsh  = {r_ff.rx_s[1], r_ff.rsh[7:1]};
						nxt_r.rbit = r_ff.rbit + 3'h1;
						if (r_ff.rbit == 3'h7) begin
							nxt_r.rst = RX_STOP;
						end
					end else begin
						// Back to idle at the stop centre, so a byte may follow at once.
						nxt_r.rst = RX_IDLE;
						if (r_ff.rx_s[1] && r_ff.uhave) begin
							nxt_r.uhave = 1'b0;
							wr          = 1'b1;
							wa          = r_ff.uab[5:0];
							wd          = r_ff.rsh;
							tload       = 1'b1;
							tbyte       = r_ff.uab;
						end else if (r_ff.rx_s[1] && r_ff.rsh[7]) begin
							tload = 1'b1;
							tbyte = r_ff.mem[r_ff.rsh[5:0]];
						end else if (r_ff.rx_s[1]) begin
							nxt_r.uhave = 1'b1;
							nxt_r.uab   = r_ff.rsh;
						end
					end
				end
			end
			default: begin
				nxt_r.rst = RX_IDLE;
			end
		endcase

		// ********************************************************
		// UART transmitter
		// ********************************************************
		if (tload) begin
			nxt_r.tbusy = 1'b1;
			nxt_r.tsh   = {1'b1, tbyte, 1'b0};
			nxt_r.tbit  = 4'h0;
			nxt_r.tcnt  = nbit - 13'h0001;
		end else if (r_ff.tbusy && tick) begin
			nxt_r.tcnt = r_ff.tcnt - 13'h0001;
			if (r_ff.tcnt == 13'h0000) begin
				nxt_r.tcnt = nbit - 13'h0001;
				nxt_r.tsh  = {1'b1, r_ff.tsh[9:1]};
				nxt_r.tbit = r_ff.tbit + 4'h1;
				if (r_ff.tbit == 4'h9) begin
					nxt_r.tbusy = 1'b0;
				end
			end
		end

		// ********************************************************
		// Register file write port
		// ********************************************************
		nxt_r.wstb = wr;
		if (wr) begin
			nxt_r.mem[wa] = wd;
			nxt_r.waddr   = wa;
			nxt_r.wdata   = wd;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff                <= '0;
			r_ff.nss_s          <= 2'h3;
			r_ff.sck_s          <= 3'h0;
			r_ff.rx_s           <= 3'h7;
			r_ff.mode           <= MODE_UART;
			r_ff.sfirst         <= 1'b1;
			r_ff.rst            <= RX_IDLE;
			r_ff.tsh            <= 10'h3ff;
			r_ff.mem[BAUD_ADDR] <= BAUD_RST;
			r_ff.mem[TPEN_ADDR] <= TPEN_RST;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	assign link.miso_o  = r_ff.miso;
	assign link.miso_oe = (r_ff.mode == MODE_SPI) && !r_ff.nss_s[1];
	assign link.tx      = r_ff.tsh[0];
	assign link.req_o   = r_ff.tbusy;
	assign link.req_oe  = (r_ff.mode == MODE_UART) && r_ff.mem[TPEN_ADDR][LINE_EN_BIT];
	assign link.mux_o   = (r_ff.rst == RX_IDLE);
	assign link.mux_oe  = (r_ff.mode == MODE_UART) && r_ff.mem[TPEN_ADDR][LINE_EN_BIT];
	assign mode         = r_ff.mode;
	assign reg_wr_stb   = r_ff.wstb;
	assign reg_wr_addr  = r_ff.waddr;
	assign reg_wr_data  = r_ff.wdata;
endmodule // hsp_device

// File: core/hsp_host.sv
// Purpose: Host end: runs one register read or write over SPI or UART on command.
// Assumes: Software programs the host baud setting to match the device.
// Notes: APB slave answers with no wait states.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module hsp_host
	import hsp_pkg::*;
#(parameter int SYS_KHZ = CLK_KHZ)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	hsp_link_if.host         link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	typedef enum logic [6:0] {
		H_IDLE  = 7'b0000001,
		H_SLO   = 7'b0000010,
		H_SHI   = 7'b0000100,
		H_STAIL = 7'b0001000,
		H_UTX   = 7'b0010000,
		H_URX   = 7'b0100000,
		H_DONE  = 7'b1000000
	} hsp_hst_t;

	typedef struct packed {
		hsp_hst_t    st;
		logic        proto;
		logic        rd;
		logic [5:0]  addr;
		logic [7:0]  wdata;
		logic [7:0]  baud;
		logic [7:0]  rdata;
		logic        done;
		logic [1:0]  miso_s;
		logic [2:0]  rx_s;
		logic [3:0]  tm;
		logic [3:0]  bi;
		logic [15:0] sh;
		logic        nss;
		logic        sck;
		logic        mosi;
		logic [18:0] acc;
		logic [19:0] tsh;
		logic [4:0]  tleft;
		logic [12:0] tcnt;
		hsp_rx_t     rst;
		logic [12:0] rcnt;
		logic [2:0]  rbit;
		logic [7:0]  rsh;
	} hsp_host_t;

	hsp_host_t r_ff;
	hsp_host_t nxt_r;

	always_comb begin
		logic        tick;
		logic        rvalid;
		logic [12:0] nbit;
		logic [7:0]  ab;
		tick   = 1'b0;
		rvalid = 1'b0;
		ab     = 8'h00;
		nxt_r  = r_ff;
		nbit   = hsp_bit_ticks(r_ff.baud);
		nxt_r.miso_s = {r_ff.miso_s[0], link.miso};
		nxt_r.rx_s   = {r_ff.rx_s[1:0], link.tx};
		nxt_r.acc    = r_ff.acc + 19'(REF_KHZ);
		if (nxt_r.acc >= 19'(SYS_KHZ)) begin
			nxt_r.acc = nxt_r.acc - 19'(SYS_KHZ);
			tick      = 1'b1;
		end

		// ********************************************************
		// APB registers
		// ********************************************************
		if (psel && penable && pwrite) begin
			if (paddr == APB_CTRL && r_ff.st == H_IDLE) begin
				nxt_r.proto = pwdata[1];
				nxt_r.rd    = pwdata[2];
				nxt_r.addr  = pwdata[13:8];
				nxt_r.wdata = pwdata[23:16];
				if (pwdata[0]) begin
					nxt_r.done = 1'b0;
					if (pwdata[1]) begin
						ab          = {pwdata[2], 1'b0, pwdata[13:8]};
						nxt_r.tsh   = pwdata[2] ? {10'h3ff, 1'b1, ab, 1'b0} :
							{1'b1, pwdata[23:16], 1'b0, 1'b1, ab, 1'b0};
						nxt_r.tleft = pwdata[2] ? 5'h0a : 5'h14;
						nxt_r.tcnt  = nbit - 13'h0001;
						nxt_r.st    = H_UTX;
					end else begin
						ab          = {pwdata[2], pwdata[13:8], 1'b0};
						nxt_r.sh    = {ab, pwdata[2] ? 8'h00 : pwdata[23:16]};
						nxt_r.mosi  = pwdata[2];
						nxt_r.nss   = 1'b0;
						nxt_r.bi    = 4'h0;
						nxt_r.tm    = 4'(SPI_HALF_CYC - 1);
						nxt_r.st    = H_SLO;
					end
				end
			end else if (paddr == APB_BAUD) begin
				nxt_r.baud = pwdata[7:0];
			end
		end

		// ********************************************************
		// UART receiver, always armed
		// ********************************************************
		case (r_ff.rst)
			RX_IDLE: begin
				if (r_ff.rx_s[2] && !r_ff.rx_s[1]) begin
					nxt_r.rst  = RX_START;
					nxt_r.rcnt = nbit >> 1;
				end
			end
			RX_START, RX_DATA, RX_STOP: begin
				if (tick) begin
					nxt_r.rcnt = r_ff.rcnt - 13'h0001;
				end
				if (tick && r_ff.rcnt == 13'h0000) begin
					nxt_r.rcnt = nbit - 13'h0001;
					if (r_ff.rst == RX_START) begin
						nxt_r.rst  = r_ff.rx_s[1] ? RX_IDLE : RX_DATA;
						nxt_r.rbit = 3'h0;
					end else if (r_ff.rst == RX_DATA) begin
						nxt_r.rsh  = {r_ff.rx_s[1], r_ff.rsh[7:1]};
						nxt_r.rbit = r_ff.rbit + 3'h1;
						if (r_ff.rbit == 3'h7) begin
							nxt_r.rst = RX_STOP;
						end
					end else begin
						nxt_r.rst = RX_IDLE;
						rvalid    = r_ff.rx_s[1];
					end
				end
			end
			default: begin
				nxt_r.rst = RX_IDLE;
			end
		endcase

		// ********************************************************
		// Transfer sequencer
		// ********************************************************
		if (r_ff.st != H_IDLE && r_ff.tm != 4'h0) begin
			nxt_r.tm = r_ff.tm - 4'h1;
		end
		case (r_ff.st)
			H_IDLE: begin
			end
			H_SLO: begin
				if (r_ff.tm == 4'h0) begin
					nxt_r.sck   = 1'b1;
					nxt_r.rdata = {r_ff.rdata[6:0], r_ff.miso_s[1]};
					nxt_r.tm    = 4'(SPI_HALF_CYC - 1);
					nxt_r.st    = H_SHI;
				end
			end
			H_SHI: begin
				if (r_ff.tm == 4'h0) begin
					nxt_r.sck = 1'b0;
					nxt_r.tm  = 4'(SPI_HALF_CYC - 1);
					if (r_ff.bi == 4'hf) begin
						nxt_r.st = H_STAIL;
					end else begin
						nxt_r.bi   = r_ff.bi + 4'h1;
						nxt_r.sh   = {r_ff.sh[14:0], 1'b0};
						nxt_r.mosi = r_ff.sh[14];
						nxt_r.st   = H_SLO;
					end
				end
			end
			H_STAIL: begin
				if (r_ff.tm == 4'h0) begin
					nxt_r.nss = 1'b1;
					nxt_r.st  = H_DONE;
				end
			end
			H_UTX: begin
				if (tick) begin
					nxt_r.tcnt = r_ff.tcnt - 13'h0001;
				end
				if (tick && r_ff.tcnt == 13'h0000) begin
					nxt_r.tcnt  = nbit - 13'h0001;
					nxt_r.tsh   = {1'b1, r_ff.tsh[19:1]};
					nxt_r.tleft = r_ff.tleft - 5'h01;
					if (r_ff.tleft == 5'h01) begin
						nxt_r.st = H_URX;
					end
				end
			end
			H_URX: begin
				if (rvalid) begin
					nxt_r.rdata = r_ff.rsh;
					nxt_r.st    = H_DONE;
				end
			end
			H_DONE: begin
				nxt_r.done = 1'b1;
				nxt_r.st   = H_IDLE;
			end
			default: begin
				nxt_r.st = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff        <= '0;
			r_ff.st     <= H_IDLE;
			r_ff.baud   <= BAUD_RST;
			r_ff.miso_s <= 2'h3;
			r_ff.rx_s   <= 3'h7;
			r_ff.nss    <= 1'b1;
			r_ff.tsh    <= 20'hfffff;
			r_ff.rst    <= RX_IDLE;
		end else begin
			r_ff <= nxt_r;
		end
	end

	always_comb begin
		prdata = 32'h00000000;
		if (paddr == APB_CTRL) begin
			prdata = {8'h00, r_ff.wdata, 2'h0, r_ff.addr, 5'h00, r_ff.rd, r_ff.proto, 1'b0};
		end else if (paddr == APB_STAT) begin
			prdata = {16'h0000, r_ff.rdata, 6'h00, r_ff.done, (r_ff.st != H_IDLE)};
		end else if (paddr == APB_BAUD) begin
			prdata = {24'h000000, r_ff.baud};
		end
	end

	assign pready    = 1'b1;
	assign pslverr   = 1'b0;
	assign link.nss  = r_ff.nss;
	assign link.sck  = r_ff.sck;
	assign link.mosi = r_ff.mosi;
	assign link.rx   = r_ff.tsh[0];
endmodule // hsp_host

// File: test/hsp_assertions.sv
// Purpose: Wire checks on the link between the device end and the host end.
// Assumes: One clock; presetn is the device reset.
// Notes: Sees the interface signals only.
`timescale 1ns/1ps
module hsp_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic nss,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic rx,
	input wire logic tx,
	input wire logic req_o,
	input wire logic mux_o
);
	logic [7:0] hi_cnt_ff;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Counts the high half of sck so the bit rate limit can be checked.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_cnt_ff <= 8'h00;
		end else begin
			hi_cnt_ff <= sck ? hi_cnt_ff + {7'h00, hi_cnt_ff != 8'hff} : 8'h00;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	mosi_edge_a:
		assert property ($changed(mosi) |-> !sck) else $error("mosi moved with sck high");
	miso_edge_a:
		assert property (miso_oe && $changed(miso_o) |-> !sck) else $error("miso moved with sck high");
	miso_release_a:
		assert property (nss [*5] |-> !miso_oe) else $error("miso driven while deselected");
	sck_idle_a:
		assert property (nss |-> !sck) else $error("sck high outside a frame");
	select_lead_a:
		assert property ($fell(nss) |-> !sck [*8]) else $error("sck rose too soon after select");
	half_period_a:
		assert property ($fell(sck) |-> hi_cnt_ff >= 8'd13) else $error("sck high half too short");
	tx_busy_a:
		assert property ($fell(tx) |-> ##[0:2] req_o) else $error("tx start without busy flag");
	rx_seen_a:
		assert property ($fell(rx) |-> ##[1:8] !mux_o) else $error("start edge not detected");

	cover property ($fell(nss));
	cover property ($fell(rx));
	cover property ($fell(tx));
endmodule // hsp_assertions

// File: test/testbench.sv
// Purpose: Drives the host end over APB and checks straps, SPI and UART transfers.
// Assumes: Both ends share one interface and one clock; the host has its own reset.
// Notes: Both ends see one reference tick per clock, so the slow UART write stays near 60 k cycles.
`timescale 1ns/1ps
module testbench
	import hsp_pkg::*;
;
	localparam int SIM_KHZ = REF_KHZ;
	typedef struct {logic s; logic i; logic e; hsp_mode_t m;} hsp_row_t;
	logic        pclk, presetn, presetn_host, strap_serial, strap_i2c, strap_ea;
	logic        psel, penable, pwrite, pready, pslverr, reg_wr_stb;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, st;
	logic [5:0]  reg_wr_addr, wr_addr;
	logic [7:0]  reg_wr_data, wr_data;
	hsp_mode_t   mode;
	int          n_errors, tests_run, wr_cnt, cnt0, n, fast;
	hsp_row_t    rows [4] = '{'{1'b0, 1'b1, 1'b1, MODE_PAR}, '{1'b1, 1'b1, 1'b0, MODE_I2C},
		'{1'b1, 1'b0, 1'b0, MODE_UART}, '{1'b1, 1'b0, 1'b1, MODE_SPI}};

	hsp_link_if i_hsp_link_if ();
	hsp_device #(.SYS_KHZ(SIM_KHZ)) i_hsp_device (.pclk(pclk), .presetn(presetn),
		.link(i_hsp_link_if.dev),
		.strap_serial(strap_serial), .strap_i2c(strap_i2c), .strap_ea(strap_ea), .mode(mode),
		.reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
	hsp_host #(.SYS_KHZ(SIM_KHZ)) i_hsp_host (.pclk(pclk), .presetn(presetn_host),
		.link(i_hsp_link_if.host),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	hsp_assertions i_hsp_assertions (.pclk(pclk), .presetn(presetn), .nss(i_hsp_link_if.nss),
		.sck(i_hsp_link_if.sck), .mosi(i_hsp_link_if.mosi), .miso_o(i_hsp_link_if.miso_o),
		.miso_oe(i_hsp_link_if.miso_oe), .rx(i_hsp_link_if.rx), .tx(i_hsp_link_if.tx),
		.req_o(i_hsp_link_if.req_o), .mux_o(i_hsp_link_if.mux_o));

	always #2 pclk = ~pclk;

	always @(posedge pclk) begin
		if (reg_wr_stb === 1'b1) begin
			wr_cnt++;
			wr_addr = reg_wr_addr;
			wr_data = reg_wr_data;
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: byte %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic check_mode(input hsp_mode_t got, input hsp_mode_t exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: mode %b, expected %b", $time, got, exp);
		end
	endtask

	// Bit period in clock cycles, worked out from the exponent and mantissa fields.
	function automatic int uart_cyc(input logic [7:0] s);
		int t;
		t = (s[7:5] == 3'h0) ? int'(s[4:0]) + 1 : (int'(s[4:0]) + 33) << (int'(s[7:5]) - 1);
		return t * SIM_KHZ / REF_KHZ;
	endfunction

	function automatic logic line_of(input logic t);
		return t ? i_hsp_link_if.tx : i_hsp_link_if.rx;
	endfunction

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		logic rdy;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Answer is read settled, half a cycle before the edge that completes the access.
		do begin
			@(negedge pclk);
			r = prdata;
			rdy = pready;
			@(posedge pclk);
		end while (rdy !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic do_reset(input logic s, input logic i, input logic e);
		@(posedge pclk);
		presetn <= 1'b0;
		presetn_host <= 1'b0;
		strap_serial <= s;
		strap_i2c <= i;
		strap_ea <= e;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		presetn_host <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask

	task automatic run_cmd(input logic u, input logic rd, input logic [5:0] a,
		input logic [7:0] d, output logic [7:0] r);
		logic [31:0] s;
		int k;
		cnt0 = wr_cnt;
		apb(1'b1, APB_CTRL, {8'h00, d, 2'b00, a, 5'h00, rd, u, 1'b1}, s);
		s = 32'h1;
		k = 0;
		while (!(s[0] === 1'b0 && s[1] === 1'b1) && k < 200000) begin
			apb(1'b0, APB_STAT, 32'h0, s);
			k++;
		end
		r = s[15:8];
	endtask

	task automatic uart_mon(input logic t, input int cyc, input logic [7:0] exp);
		logic [7:0] b;
		while (line_of(t) !== 1'b0) @(posedge pclk);
		repeat (cyc / 2) @(posedge pclk);
		check_byte({7'h00, line_of(t)}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			repeat (cyc) @(posedge pclk);
			b[i] = line_of(t);
		end
		repeat (cyc) @(posedge pclk);
		check_byte({7'h00, line_of(t)}, 8'h01);
		check_byte(b, exp);
	endtask

	task automatic spi_txn(input logic rd, input logic [5:0] a, input logic [7:0] d,
		input logic [7:0] exp);
		logic [15:0] mo, mi;
		logic [7:0]  r;
		fork
			for (int i = 15; i >= 0; i--) begin
				@(posedge i_hsp_link_if.sck);
				mo[i] = i_hsp_link_if.mosi;
				mi[i] = i_hsp_link_if.miso;
			end
			run_cmd(1'b0, rd, a, d, r);
		join
		check_byte(mo[15:8], {rd, a, 1'b0});
		check_byte(mo[7:0], rd ? 8'h00 : d);
		check_byte(rd ? mi[7:0] : d, rd ? exp : wr_data);
		check_byte(rd ? r : {2'b00, wr_addr}, rd ? exp : {2'b00, a});
	endtask

	task automatic uart_txn(input logic rd, input logic [5:0] a, input logic [7:0] d,
		input logic [7:0] exp);
		logic [7:0] r;
		fork
			uart_mon(1'b0, fast, {rd, 1'b0, a});
			uart_mon(1'b1, fast, rd ? exp : {2'b00, a});
			run_cmd(1'b1, rd, a, d, r);
		join
		check_byte(r, rd ? exp : {2'b00, a});
		check_byte(rd ? 8'(wr_cnt - cnt0) : wr_data, rd ? 8'h00 : d);
	endtask

	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{pclk, presetn, presetn_host, psel, penable, pwrite} = 6'h00;
		{strap_serial, strap_i2c, strap_ea, paddr, pwdata} = '0;
		{n_errors, tests_run, wr_cnt} = '0;
		fast = uart_cyc(8'h15);
		foreach (rows[k]) begin
			do_reset(rows[k].s, rows[k].i, rows[k].e);
			check_mode(mode, rows[k].m);
		end
		strap_ea <= 1'b0;
		repeat (10) @(posedge pclk);
		check_mode(mode, MODE_SPI);
		$display("test straps done");
		spi_txn(1'b0, 6'h12, 8'ha5, 8'h00);
		spi_txn(1'b1, 6'h12, 8'h00, 8'ha5);
		spi_txn(1'b1, BAUD_ADDR, 8'h00, BAUD_RST);
		spi_txn(1'b1, TPEN_ADDR, 8'h00, TPEN_RST);
		apb(1'b0, 12'hffc, 32'h0, st);
		check_byte({7'h00, |st}, 8'h00);
		$display("test spi done");
		do_reset(1'b1, 1'b0, 1'b0);
		check_mode(mode, MODE_UART);
		check_byte({6'h00, i_hsp_link_if.req_oe, i_hsp_link_if.mux_oe}, 8'h03);
		// Reset baud rate is slow; one write switches the device to the fast setting.
		cnt0 = wr_cnt;
		fork
			uart_mon(1'b0, uart_cyc(BAUD_RST), {2'b00, BAUD_ADDR});
			apb(1'b1, APB_CTRL, {8'h00, 8'h15, 2'b00, BAUD_ADDR, 8'h03}, st);
		join
		for (n = 0; wr_cnt == cnt0 && n < 400000; n++) @(posedge pclk);
		check_byte({2'b00, wr_addr}, {2'b00, BAUD_ADDR});
		check_byte(wr_data, 8'h15);
		for (n = 0; i_hsp_link_if.req !== 1'b1 && n < 40000; n++) @(posedge pclk);
		for (n = 0; i_hsp_link_if.req === 1'b1 && n < 400000; n++) @(posedge pclk);
		presetn_host <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn_host <= 1'b1;
		apb(1'b1, APB_BAUD, 32'h15, st);
		uart_txn(1'b0, 6'h05, 8'h5a, 8'h00);
		uart_txn(1'b1, 6'h05, 8'h00, 8'h5a);
		uart_txn(1'b1, BAUD_ADDR, 8'h00, 8'h15);
		uart_txn(1'b0, TPEN_ADDR, 8'h00, 8'h00);
		check_byte({6'h00, i_hsp_link_if.req_oe, i_hsp_link_if.mux_oe}, 8'h00);
		$display("test uart done");
		complete_run();
	end

	// About 62 k cycles are expected, mostly the slow UART write and the slow start bit of its echo.
	initial begin
		repeat (90000) @(posedge pclk);
		n_errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		complete_run();
	end
endmodule // testbench
